// File: hw/iar_pkg.sv
// Purpose: constants for the address and interrupt register slice
// Assumes: AXI4-Lite slave, 32-bit data, one register per aligned word
// Notes: offsets are byte addresses
package iar_pkg;
  localparam logic [4:0] OFS_OWN_ADDRESS = 5'h00;
  localparam logic [4:0] OFS_TARGET_SLAVE_ADDRESS = 5'h04;
  localparam logic [4:0] OFS_INTERRUPT_ENABLE = 5'h08;
  localparam logic [4:0] OFS_INTERRUPT_FLAGS = 5'h0c;
  localparam logic [4:0] OFS_INTERRUPT_VECTOR = 5'h10;
  localparam logic [4:0] OFS_CONTROL = 5'h14;
  // control register fields
  localparam int CTL_TEN_BIT_OWN = 0;
  localparam int CTL_TEN_BIT_TARGET = 1;
  localparam int CTL_MASTER_SELECT = 2;
  localparam int CTL_TX_DMA = 3;
  localparam int CTL_RX_DMA = 4;
  // interrupt bit positions, shared by enable and flags
  localparam int BIT_ARB_LOST = 0;
  localparam int BIT_NO_ACK = 1;
  localparam int BIT_OWN_ADDR = 2;
  localparam int BIT_ACCESS_READY = 3;
  localparam int BIT_RX_READY = 4;
  localparam int BIT_TX_READY = 5;
  localparam int BIT_GENERAL_CALL = 6;
  localparam int BIT_START_DETECT = 7;
  localparam logic [15:0] RST_ADDR = 16'h0000;
  localparam logic [7:0] RST_IRQ = 8'h00;
  localparam logic [4:0] RST_CTL = 5'h00;
  localparam logic [9:0] MASK_7BIT = 10'h07f;
  localparam logic [9:0] MASK_10BIT = 10'h3ff;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage : iar_pkg

// File: hw/iar_vector.sv
// Purpose: priority encoder from pending flags to vector value
// Assumes: bit 0 has highest priority
// Notes: purely combinational
`timescale 1ns/1ps
module iar_vector
(
  input wire logic [7:0] pending,
  output logic [15:0] vector,
  output logic [7:0] onehot
);
  import iar_pkg::*;

  always_comb
  begin
    vector = 16'h0000;
    onehot = 8'h00;
    // scan from lowest priority upward so the highest wins
    for (int i = 7; i >= 0; i--)
    begin
      if (pending[i])
      begin
        vector = 16'((i + 1) * 2);
        onehot = 8'(1 << i);
      end
    end
  end
endmodule : iar_vector

// File: hw/iar_regs.sv
// Contract
// - 10-bit own address, bits 15:10 zero
// - 7-bit target address, bits 15:7 zero
// - 10-bit target address, bits 15:10 zero
// - tx dma suppresses tx ready interrupt
// - rx dma suppresses rx ready interrupt
// - enable register, reset zero, bit order
// - flag register mirrors enable, read/write
// - vector codes 000h to 010h
// - arbitration lost highest, start lowest
// - master select cleared on loss, stop
//
// Purpose: own/target address and interrupt registers over AXI4-Lite
// Assumes: engine events are same-clock one-cycle pulses
// Notes: unmapped addresses answer SLVERR, read zero
`timescale 1ns/1ps
module iar_regs
(
  input wire logic CLK,
  input wire logic RST,
  input wire logic [4:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [4:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic [7:0] EVENT_SET,
  input wire logic ARB_LOST,
  input wire logic STOP_SENT,
  output logic [9:0] OWN_ADDRESS,
  output logic [9:0] TARGET_SLAVE_ADDRESS,
  output logic MASTER_SELECT,
  output logic TX_DMA_ENABLE,
  output logic RX_DMA_ENABLE,
  output logic IRQ
);
  import iar_pkg::*;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [9:0] own_address;
  logic [9:0] target_slave_address;
  logic [7:0] interrupt_enable;
  logic [7:0] interrupt_flags;
  logic [4:0] control;
  logic [4:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic aw_held;
  logic w_held;
  logic do_write;
  logic do_read;
  logic [7:0] sw_set;
  logic [7:0] sw_clr;
  logic [7:0] rd_clr;
  logic [7:0] effective;
  logic [15:0] vector;
  logic [7:0] vector_hit;
  logic [31:0] next_rdata;
  logic next_rerr;

  function automatic logic [9:0] addr_mask(input logic ten_bit);
    addr_mask = ten_bit ? MASK_10BIT : MASK_7BIT;
  endfunction : addr_mask

  function automatic logic [9:0] merge_addr(input logic [9:0] old,
    input logic [31:0] d, input logic [3:0] s, input logic ten_bit);
    logic [9:0] v;
    v = old;
    if (s[0])
    begin
      v[7:0] = d[7:0];
    end
    if (s[1])
    begin
      v[9:8] = d[9:8];
    end
    merge_addr = v & addr_mask(ten_bit);
  endfunction : merge_addr

  // ----------------------------------------------------------------
  // write channel capture
  // ----------------------------------------------------------------
  assign do_write = aw_held && w_held && !S_AXI_BVALID;

  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      aw_held <= 1'b0;
      aw_addr <= 5'h00;
      S_AXI_AWREADY <= 1'b0;
    end
    else
    begin
      S_AXI_AWREADY <= !aw_held && !S_AXI_AWREADY && S_AXI_AWVALID;
      if (S_AXI_AWVALID && S_AXI_AWREADY)
      begin
        aw_held <= 1'b1;
        aw_addr <= S_AXI_AWADDR;
      end
      else if (do_write)
      begin
        aw_held <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      S_AXI_WREADY <= 1'b0;
    end
    else
    begin
      S_AXI_WREADY <= !w_held && !S_AXI_WREADY && S_AXI_WVALID;
      if (S_AXI_WVALID && S_AXI_WREADY)
      begin
        w_held <= 1'b1;
        w_data <= S_AXI_WDATA;
        w_strb <= S_AXI_WSTRB;
      end
      else if (do_write)
      begin
        w_held <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= RESP_OKAY;
    end
    else if (do_write)
    begin
      S_AXI_BVALID <= 1'b1;
      S_AXI_BRESP <= (aw_addr <= OFS_CONTROL && aw_addr[1:0] == 2'b00) ?
        RESP_OKAY : RESP_SLVERR;
    end
    else if (S_AXI_BREADY)
    begin
      S_AXI_BVALID <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // address and control registers
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      own_address <= RST_ADDR[9:0];
      target_slave_address <= RST_ADDR[9:0];
    end
    else if (do_write && aw_addr == OFS_OWN_ADDRESS)
    begin
      own_address <= merge_addr(own_address, w_data, w_strb,
        control[CTL_TEN_BIT_OWN]);
    end
    else if (do_write && aw_addr == OFS_TARGET_SLAVE_ADDRESS)
    begin
      target_slave_address <= merge_addr(target_slave_address, w_data,
        w_strb, control[CTL_TEN_BIT_TARGET]);
    end
  end

  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      control <= RST_CTL;
    end
    else
    begin
      if (do_write && aw_addr == OFS_CONTROL && w_strb[0])
      begin
        control <= w_data[4:0];
      end
      // hardware clear beats a software set in the same cycle
      if (ARB_LOST || STOP_SENT)
      begin
        control[CTL_MASTER_SELECT] <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // interrupt enable, flags, vector
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      interrupt_enable <= RST_IRQ;
    end
    else if (do_write && aw_addr == OFS_INTERRUPT_ENABLE && w_strb[0])
    begin
      interrupt_enable <= w_data[7:0];
    end
  end

  assign sw_set = (do_write && aw_addr == OFS_INTERRUPT_FLAGS && w_strb[0])
    ? w_data[7:0] : 8'h00;
  assign sw_clr = (do_write && aw_addr == OFS_INTERRUPT_FLAGS && w_strb[0])
    ? ~w_data[7:0] : 8'h00;
  assign do_read = S_AXI_ARVALID && S_AXI_ARREADY;
  assign rd_clr = (do_read && S_AXI_ARADDR == OFS_INTERRUPT_VECTOR) ?
    vector_hit : 8'h00;

  // events set over any clear in the same cycle
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      interrupt_flags <= RST_IRQ;
    end
    else
    begin
      interrupt_flags <= ((interrupt_flags & ~sw_clr & ~rd_clr) | sw_set)
        | EVENT_SET;
    end
  end

  // dma owns the ready flags, so they never raise IRQ
  always_comb
  begin
    effective = interrupt_flags;
    if (control[CTL_TX_DMA])
    begin
      effective[BIT_TX_READY] = 1'b0;
    end
    if (control[CTL_RX_DMA])
    begin
      effective[BIT_RX_READY] = 1'b0;
    end
  end

  // vector reports raw pending flags, not gated by enables
  iar_vector u_vector
  (
    .pending(interrupt_flags),
    .vector(vector),
    .onehot(vector_hit)
  );

  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      IRQ <= 1'b0;
    end
    else
    begin
      IRQ <= |(effective & interrupt_enable);
    end
  end

  // ----------------------------------------------------------------
  // read channel
  // ----------------------------------------------------------------
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    next_rerr = 1'b0;
    unique case (S_AXI_ARADDR)
      OFS_OWN_ADDRESS: next_rdata[9:0] = own_address;
      OFS_TARGET_SLAVE_ADDRESS: next_rdata[9:0] = target_slave_address;
      OFS_INTERRUPT_ENABLE: next_rdata[7:0] = interrupt_enable;
      OFS_INTERRUPT_FLAGS: next_rdata[7:0] = interrupt_flags;
      OFS_INTERRUPT_VECTOR: next_rdata[15:0] = vector;
      OFS_CONTROL: next_rdata[4:0] = control;
      default: next_rerr = 1'b1;
    endcase
  end

  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h0000_0000;
      S_AXI_RRESP <= RESP_OKAY;
    end
    else
    begin
      S_AXI_ARREADY <= !S_AXI_RVALID && !S_AXI_ARREADY && S_AXI_ARVALID;
      if (do_read)
      begin
        S_AXI_RVALID <= 1'b1;
        S_AXI_RDATA <= next_rdata;
        S_AXI_RRESP <= next_rerr ? RESP_SLVERR : RESP_OKAY;
      end
      else if (S_AXI_RREADY)
      begin
        S_AXI_RVALID <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // outputs to the bus engine
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      OWN_ADDRESS <= RST_ADDR[9:0];
      TARGET_SLAVE_ADDRESS <= RST_ADDR[9:0];
      MASTER_SELECT <= 1'b0;
      TX_DMA_ENABLE <= 1'b0;
      RX_DMA_ENABLE <= 1'b0;
    end
    else
    begin
      OWN_ADDRESS <= own_address;
      TARGET_SLAVE_ADDRESS <= target_slave_address;
      MASTER_SELECT <= control[CTL_MASTER_SELECT];
      TX_DMA_ENABLE <= control[CTL_TX_DMA];
      RX_DMA_ENABLE <= control[CTL_RX_DMA];
    end
  end
endmodule : iar_regs

// File: tb/iar_regs_checker.sv
// Purpose: port checks on the register slice
// Assumes: one clock domain
// Notes: vector reads are tracked from the AR handshake
`timescale 1ns/1ps
module iar_regs_checker
(
  input wire logic CLK,
  input wire logic RST,
  input wire logic S_AXI_AWREADY,
  input wire logic [4:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic ARB_LOST,
  input wire logic STOP_SENT,
  input wire logic MASTER_SELECT
);
  import iar_pkg::*;
  // ----
  // helpers
  // ----
  logic vec_rd;
  always_ff @(posedge CLK or posedge RST)
    if (RST)
      vec_rd <= 1'b0;
    else if (S_AXI_ARVALID && S_AXI_ARREADY)
      vec_rd <= S_AXI_ARADDR == OFS_INTERRUPT_VECTOR;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  sequence ar_hs;
    S_AXI_ARVALID && S_AXI_ARREADY;
  endsequence
  awready_pulse_a: assert property (S_AXI_AWREADY |=> !S_AXI_AWREADY)
    else $error("awready too long");
  arready_pulse_a: assert property (S_AXI_ARREADY |=> !S_AXI_ARREADY)
    else $error("arready too long");
  read_answer_a: assert property (ar_hs |=> S_AXI_RVALID)
    else $error("read answer late");
  rvalid_hold_a: assert property (S_AXI_RVALID && !S_AXI_RREADY |=>
    S_AXI_RVALID && $stable(S_AXI_RDATA)) else $error("rvalid dropped");
  bvalid_hold_a: assert property (S_AXI_BVALID && !S_AXI_BREADY |=>
    S_AXI_BVALID) else $error("bvalid dropped");
  read_upper_a: assert property (S_AXI_RVALID |->
    S_AXI_RDATA[31:16] == '0) else $error("upper read bits set");
  vector_code_a: assert property (S_AXI_RVALID && vec_rd |->
    S_AXI_RDATA[31:5] == '0 && !S_AXI_RDATA[0] && S_AXI_RDATA[4:0] <= 5'h10)
    else $error("bad vector code");
  master_clear_a: assert property (ARB_LOST || STOP_SENT |=>
    ##1 !MASTER_SELECT) else $error("master select kept");
endmodule : iar_regs_checker

bind iar_regs iar_regs_checker iar_regs_checker_inst (.*);

// File: tb/iar_engine_model.sv
// Purpose: bus engine stand-in that pulses events
// Assumes: link clock runs only while a request is pending
// Notes: events land one cycle long at a sampled link clock rise
`timescale 1ns/1ps
module iar_engine_model
(
  input wire logic clk,
  input wire logic rst,
  input wire logic link_clk,
  input wire logic req,
  input wire logic [9:0] req_bits,
  output logic busy,
  output logic [9:0] pulses
);
  logic [2:0] lk;
  logic [9:0] held;
  // two flops first: the link clock is unrelated in phase
  always_ff @(posedge clk or posedge rst)
    if (rst)
      lk <= '0;
    else
      lk <= {lk[1:0], link_clk};
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      busy <= 1'b0;
      held <= '0;
      pulses <= '0;
    end
    else
    begin
      pulses <= '0;
      if (req)
      begin
        busy <= 1'b1;
        held <= req_bits;
      end
      else if (busy && lk[1] && !lk[2])
      begin
        busy <= 1'b0;
        pulses <= held;
      end
    end
endmodule : iar_engine_model

// File: tb/tb_i2c_address_and_interrupt_regs.sv
// Purpose: self-checking bench for the register slice
// Assumes: one write or read at a time
// Notes: watchdog span is many times the expected run
`timescale 1ns/1ps
module tb_i2c_address_and_interrupt_regs;
  import iar_pkg::*;
  logic clk = 0, rst = 1, link = 0, req = 0, busy;
  logic [4:0] awa = '0, ara = '0;
  logic [31:0] wd = '0, rdat, r;
  logic awv = 0, wv = 0, brd = 0, arv = 0, rrd = 0;
  logic awr, wr_r, bv, arr, rv, irq, ms, txd, rxd;
  logic [1:0] brs, rrs;
  logic [3:0] ws = 4'hf;
  logic [9:0] own, tgt, rb = '0, mk, pl;
  logic [33:0] q[$], e;
  int fail_count = 0, checked = 0;
  always #25 clk = ~clk;
  initial
  begin
    #13;
    forever #200 link = busy ? ~link : 1'b0;
  end
  iar_regs iar_regs_inst (.CLK(clk), .RST(rst),
    .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
    .S_AXI_WDATA(wd), .S_AXI_WSTRB(ws), .S_AXI_WVALID(wv),
    .S_AXI_WREADY(wr_r), .S_AXI_BRESP(brs), .S_AXI_BVALID(bv),
    .S_AXI_BREADY(brd), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv),
    .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdat), .S_AXI_RRESP(rrs),
    .S_AXI_RVALID(rv), .S_AXI_RREADY(rrd), .EVENT_SET(pl[7:0]),
    .ARB_LOST(pl[8]), .STOP_SENT(pl[9]), .OWN_ADDRESS(own),
    .TARGET_SLAVE_ADDRESS(tgt), .MASTER_SELECT(ms),
    .TX_DMA_ENABLE(txd), .RX_DMA_ENABLE(rxd), .IRQ(irq));
  iar_engine_model iar_engine_model_inst (.clk(clk), .rst(rst),
    .link_clk(link), .req(req), .req_bits(rb), .busy(busy), .pulses(pl));
  task finish_test;
    if (fail_count == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : finish_test
  task cmp(input string n, input logic [33:0] s, input logic [33:0] x);
    checked++;
    if (s !== x)
    begin
      $display("wrong value %s expected %h seen %h", n, x, s);
      fail_count++;
    end
  endtask : cmp
  task wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] x);
    bit ap, dp;
    ap = 1;
    dp = 1;
    @(posedge clk);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    brd <= 1'b1;
    q.push_back({x, 32'h0});
    while (ap || dp)
    begin
      @(posedge clk);
      if (ap && awr)
      begin
        ap = 0;
        awv <= 1'b0;
      end
      if (dp && wr_r)
      begin
        dp = 0;
        wv <= 1'b0;
      end
    end
    do @(posedge clk); while (bv !== 1'b1);
    brd <= 1'b0;
  endtask : wr
  task rd(input logic [4:0] a, input logic [31:0] d, input logic [1:0] x);
    @(posedge clk);
    ara <= a;
    arv <= 1'b1;
    rrd <= 1'b1;
    q.push_back({x, d});
    do @(posedge clk); while (arr !== 1'b1);
    arv <= 1'b0;
    do @(posedge clk); while (rv !== 1'b1);
    rrd <= 1'b0;
  endtask : rd
  task ev(input logic [9:0] b);
    @(posedge clk);
    req <= 1'b1;
    rb <= b;
    @(posedge clk);
    req <= 1'b0;
    do @(posedge clk); while (busy);
  endtask : ev
  task irq_is(input logic x);
    repeat (2) @(posedge clk);
    cmp("irq", {33'h0, irq}, {33'h0, x});
  endtask : irq_is
  // ----
  // result watcher
  // ----
  always @(posedge clk)
    if ((rv && rrd) || (bv && brd))
    begin
      e = q.pop_front();
      cmp(rv ? "rdata" : "bresp", rv ? {rrs, rdat} : {brs, 32'h0}, e);
    end
  initial
  begin
    #500_000;
    fail_count++;
    finish_test;
  end
  initial
  begin
    r = $urandom(58544);
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 6; i++)
      rd(5'(i * 4), 32'h0, RESP_OKAY);
    rd(5'h18, 32'h0, RESP_SLVERR);
    wr(5'h18, 32'h0000_00ff, RESP_SLVERR);
    for (int m = 0; m < 2; m++)
    begin
      r = $urandom;
      mk = m ? MASK_10BIT : MASK_7BIT;
      wr(OFS_CONTROL, m ? 32'h3 : 32'h0, RESP_OKAY);
      wr(OFS_OWN_ADDRESS, r, RESP_OKAY);
      wr(OFS_TARGET_SLAVE_ADDRESS, ~r, RESP_OKAY);
      rd(OFS_OWN_ADDRESS, {22'h0, r[9:0] & mk}, RESP_OKAY);
      rd(OFS_TARGET_SLAVE_ADDRESS, {22'h0, ~r[9:0] & mk}, RESP_OKAY);
      cmp("own_address", {24'h0, own}, {24'h0, r[9:0] & mk});
      cmp("target", {24'h0, tgt}, {24'h0, ~r[9:0] & mk});
    end
    // low strobe only: address bits 9:8 must survive the write
    ws <= 4'h1;
    wr(OFS_OWN_ADDRESS, 32'h0000_0000, RESP_OKAY);
    ws <= 4'hf;
    rd(OFS_OWN_ADDRESS, {22'h0, r[9:8], 8'h00}, RESP_OKAY);
    wr(OFS_INTERRUPT_ENABLE, 32'h0000_00a5, RESP_OKAY);
    rd(OFS_INTERRUPT_ENABLE, 32'h0000_00a5, RESP_OKAY);
    wr(OFS_INTERRUPT_FLAGS, 32'h0000_005a, RESP_OKAY);
    rd(OFS_INTERRUPT_FLAGS, 32'h0000_005a, RESP_OKAY);
    wr(OFS_INTERRUPT_FLAGS, 32'h0000_00ff, RESP_OKAY);
    for (int i = 1; i < 10; i++)
      rd(OFS_INTERRUPT_VECTOR, 32'(i < 9 ? 2 * i : 0), RESP_OKAY);
    wr(OFS_INTERRUPT_ENABLE, 32'h0000_00ff, RESP_OKAY);
    for (int k = 0; k < 8; k++)
    begin
      ev(10'(1 << k));
      irq_is(1'b1);
      rd(OFS_INTERRUPT_VECTOR, 32'(2 * (k + 1)), RESP_OKAY);
      irq_is(1'b0);
    end
    wr(OFS_CONTROL, 32'h0000_0018, RESP_OKAY);
    ev(10'h030);
    cmp("dma_enables", {32'h0, txd, rxd}, {32'h0, 2'b11});
    irq_is(1'b0);
    wr(OFS_CONTROL, 32'h0000_0010, RESP_OKAY);
    irq_is(1'b1);
    wr(OFS_CONTROL, 32'h0000_0000, RESP_OKAY);
    wr(OFS_INTERRUPT_ENABLE, 32'h0000_00cf, RESP_OKAY);
    irq_is(1'b0);
    wr(OFS_INTERRUPT_ENABLE, 32'h0000_00ef, RESP_OKAY);
    irq_is(1'b1);
    wr(OFS_INTERRUPT_FLAGS, 32'h0000_0000, RESP_OKAY);
    irq_is(1'b0);
    for (int k = 0; k < 2; k++)
    begin
      wr(OFS_CONTROL, 32'h0000_0004, RESP_OKAY);
      rd(OFS_CONTROL, 32'h0000_0004, RESP_OKAY);
      ev(k ? 10'h200 : 10'h100);
      rd(OFS_CONTROL, 32'h0000_0000, RESP_OKAY);
      cmp("master_select", {33'h0, ms}, 34'h0);
    end
    finish_test;
  end
endmodule : tb_i2c_address_and_interrupt_regs
